// file: verilog/lock_blank_pkg.sv
// Package with register map, field positions, reset values and carrier types for the lock and blank indicator
`default_nettype none
package lock_blank_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  // Control register fields
  localparam int CTRL_BLANK_HOLD_BIT = 0;
  localparam int CTRL_VDRIVE_EN_BIT = 1;
  localparam int CTRL_XRAY_CLEAR_BIT = 2;
  // Status register fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_BLANK_BIT = 1;
  localparam int STAT_XRAY_BIT = 2;
  localparam int STAT_SUPPLY_LOW_BIT = 3;
  localparam int STAT_CODE_LSB = 4;
  // Values after reset
  localparam logic CTRL_BLANK_HOLD_RESET = 1'b1;
  localparam logic CTRL_VDRIVE_EN_RESET = 1'b1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Four composite levels: bit1 = blanking, bit0 = loop locked
  typedef enum logic [1:0] {
    LVL_UNLOCK_ACTIVE = 2'b00,
    LVL_LOCK_ACTIVE = 2'b01,
    LVL_UNLOCK_BLANK = 2'b10,
    LVL_LOCK_BLANK = 2'b11
  } level_e;

  // Raw deflection timing inputs that travel together
  typedef struct packed {
    logic loop_locked;
    logic vsync;
    logic vosc_discharge;
    logic supply_low;
    logic xray_over;
  } timing_in_s;
endpackage
`default_nettype wire

// file: verilog/lock_blank_indicator.sv
// Composite loop lock and early vertical blanking indicator with an AXI4-Lite control slave
//
// How it works
// RULE1: The output carries one of four codes, one for each pairing of lock state and blanking state.
// RULE2: Blanking starts at the rising edge of vertical sync or oscillator discharge, whichever is first.
// RULE3: Blanking ends at the falling edge of the oscillator discharge, whatever sync does.
// RULE4: Blanking is not stretched to cover the whole retrace, only the generated pulse.
// RULE5: With the hold bit at 1, its reset value, the blanking code is shown all the time, lock picking which.
// RULE6: A low supply forces permanent blanking whatever the hold bit says.
// RULE7: A latched over-voltage protection condition forces permanent blanking.
// RULE8: Clearing the vertical drive enable bit forces permanent blanking.
// RULE9: The protection latch sets when the input trips and clears only on low supply or a written clear bit.
// RULE10: With hold at 0 and nothing forcing, blanking shows only during the pulse, the active code otherwise.
`default_nettype none
module lock_blank_indicator (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lock_blank_pkg::timing_in_s timing_in,
  output logic [1:0] lock_blank_composite_out,
  output logic vertical_drive_out_en,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Two-stage synchronisers for the pin inputs
  lock_blank_pkg::timing_in_s sync1_reg;
  lock_blank_pkg::timing_in_s sync2_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= timing_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Previous values for edge detection, read from the second stage only
  logic vsync_prev_reg;
  logic vosc_prev_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vsync_prev_reg <= 1'b0;
      vosc_prev_reg <= 1'b0;
    end else begin
      vsync_prev_reg <= sync2_reg.vsync;
      vosc_prev_reg <= sync2_reg.vosc_discharge;
    end
  end

  wire logic vsync_rise = sync2_reg.vsync & ~vsync_prev_reg;
  wire logic vosc_rise = sync2_reg.vosc_discharge & ~vosc_prev_reg;
  wire logic vosc_fall = ~sync2_reg.vosc_discharge & vosc_prev_reg;

  // Early blanking pulse: first leading edge starts, discharge trailing edge ends
  logic pulse_reg;
  logic pulse_next;
  assign pulse_next = vosc_fall ? 1'b0 : // see RULE3 see RULE4
                      ((vsync_rise | vosc_rise) ? 1'b1 : pulse_reg); // see RULE2
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  // Control register and write handshake
  logic blank_hold_select_reg;
  logic vertical_drive_enable_reg;
  logic xray_latch_clear_reg;
  logic aw_seen_reg;
  logic w_seen_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic aw_have = aw_seen_reg | aw_take;
  wire logic w_have = w_seen_reg | w_take;
  wire logic [3:0] wr_addr = aw_seen_reg ? awaddr_reg : s_axi_awaddr;
  wire logic [31:0] wr_data = w_seen_reg ? wdata_reg : s_axi_wdata;
  wire logic [3:0] wr_strb = w_seen_reg ? wstrb_reg : s_axi_wstrb;
  wire logic wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire logic wr_ctrl = wr_fire & (wr_addr == lock_blank_pkg::CTRL_OFFSET);
  wire logic wr_ok = (wr_addr == lock_blank_pkg::CTRL_OFFSET) | (wr_addr == lock_blank_pkg::STATUS_OFFSET);
  wire logic wr_ctrl_lane0 = wr_ctrl & wr_strb[0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_seen_reg <= 1'b0;
      w_seen_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lock_blank_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_seen_reg <= aw_have & ~wr_fire;
      w_seen_reg <= w_have & ~wr_fire;
      s_axi_awready <= ~(aw_have | s_axi_bvalid) | (s_axi_bvalid & s_axi_bready & ~aw_seen_reg);
      s_axi_wready <= ~(w_have | s_axi_bvalid) | (s_axi_bvalid & s_axi_bready & ~w_seen_reg);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? lock_blank_pkg::RESP_OKAY : lock_blank_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control bits; clear bit is a one-cycle pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blank_hold_select_reg <= lock_blank_pkg::CTRL_BLANK_HOLD_RESET;
      vertical_drive_enable_reg <= lock_blank_pkg::CTRL_VDRIVE_EN_RESET;
      xray_latch_clear_reg <= 1'b0;
    end else begin
      xray_latch_clear_reg <= wr_ctrl_lane0 & wr_data[lock_blank_pkg::CTRL_XRAY_CLEAR_BIT];
      if (wr_ctrl_lane0) begin
        blank_hold_select_reg <= wr_data[lock_blank_pkg::CTRL_BLANK_HOLD_BIT];
        vertical_drive_enable_reg <= wr_data[lock_blank_pkg::CTRL_VDRIVE_EN_BIT];
      end
    end
  end

  // Protection latch: trip sets and wins, low supply or clear bit resets
  logic xray_latch_reg;
  logic xray_latch_next;
  assign xray_latch_next = sync2_reg.xray_over ? 1'b1 : // see RULE9
                           ((sync2_reg.supply_low | xray_latch_clear_reg) ? 1'b0 : xray_latch_reg);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xray_latch_reg <= 1'b0;
    end else begin
      xray_latch_reg <= xray_latch_next;
    end
  end

  // Blanking selection and composite encoding
  wire logic force_blank = sync2_reg.supply_low | xray_latch_reg | ~vertical_drive_enable_reg; // see RULE6 see RULE7 see RULE8
  wire logic blank_now = blank_hold_select_reg | force_blank | pulse_reg; // see RULE5 see RULE10
  lock_blank_pkg::level_e level_next;
  assign level_next = lock_blank_pkg::level_e'({blank_now, sync2_reg.loop_locked}); // see RULE1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_blank_composite_out <= lock_blank_pkg::LVL_UNLOCK_BLANK;
      vertical_drive_out_en <= 1'b0;
    end else begin
      lock_blank_composite_out <= level_next;
      vertical_drive_out_en <= vertical_drive_enable_reg;
    end
  end

  // Read channel
  wire logic rd_take = s_axi_arvalid & s_axi_arready;
  wire logic [31:0] ctrl_word = {29'h0, 1'b0, vertical_drive_enable_reg, blank_hold_select_reg};
  wire logic [31:0] stat_word = {26'h0, lock_blank_composite_out, sync2_reg.supply_low, xray_latch_reg,
                                 pulse_reg, sync2_reg.loop_locked};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= lock_blank_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= (s_axi_araddr == lock_blank_pkg::CTRL_OFFSET) ? ctrl_word :
                     ((s_axi_araddr == lock_blank_pkg::STATUS_OFFSET) ? stat_word : 32'h0);
      s_axi_rresp <= ((s_axi_araddr == lock_blank_pkg::CTRL_OFFSET) | (s_axi_araddr == lock_blank_pkg::STATUS_OFFSET))
                     ? lock_blank_pkg::RESP_OKAY : lock_blank_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  sequence discharge_fall_s;
    vosc_prev_reg && !sync2_reg.vosc_discharge;
  endsequence
  sequence leading_edge_s;
    (sync2_reg.vsync && !vsync_prev_reg) || (sync2_reg.vosc_discharge && !vosc_prev_reg);
  endsequence

  pulse_start_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE2
    leading_edge_s ##0 !vosc_fall |=> pulse_reg) else $error("Blanking pulse did not start");
  pulse_end_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE3
    discharge_fall_s |=> !pulse_reg) else $error("Blanking pulse did not end on discharge fall");
  pulse_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE4
    !pulse_reg && !(sync2_reg.vsync && !vsync_prev_reg) && !(sync2_reg.vosc_discharge && !vosc_prev_reg)
    |=> !pulse_reg) else $error("Blanking pulse rose without a leading edge");
  code_map_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE1
    ##1 lock_blank_composite_out == {$past(blank_now), $past(sync2_reg.loop_locked)})
    else $error("Composite code does not match lock and blank");
  hold_blank_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE5
    blank_hold_select_reg |=> lock_blank_composite_out[1]) else $error("Hold bit did not blank");
  supply_blank_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE6
    sync2_reg.supply_low |=> lock_blank_composite_out[1]) else $error("Low supply did not blank");
  xray_blank_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE7
    xray_latch_reg |=> lock_blank_composite_out[1]) else $error("Protection latch did not blank");
  vdrive_blank_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE8
    !vertical_drive_enable_reg |=> lock_blank_composite_out[1]) else $error("Drive disable did not blank");
  xray_latch_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE9
    xray_latch_reg && !sync2_reg.supply_low && !xray_latch_clear_reg |=> xray_latch_reg)
    else $error("Protection latch dropped without a clear");
  xray_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE9
    sync2_reg.xray_over |=> xray_latch_reg) else $error("Protection latch did not set");
  active_level_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE10
    !blank_hold_select_reg && !force_blank && !pulse_reg |=> !lock_blank_composite_out[1])
    else $error("Blanking shown outside the pulse");
endmodule
`default_nettype wire

// file: bench/deflection_source.sv
// Deflection timing source model that feeds the indicator one vertical frame on request
`default_nettype none
module deflection_source (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic sync_first,
  input wire logic locked,
  input wire logic supply_low,
  input wire logic xray_over,
  output wire lock_blank_pkg::timing_in_s timing_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_reg;
  logic vs;
  logic vd;
  // Frame counter, idle at zero, one frame lasts 40 cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_reg <= 6'h00;
    else if (cnt_reg != 6'h00 || go) cnt_reg <= (cnt_reg == 6'h28) ? 6'h00 : cnt_reg + 6'h01;
  end
  // Sync outlasts discharge so only the discharge fall may end blanking
  assign vs = cnt_reg >= (sync_first ? 6'h01 : 6'h05) && cnt_reg <= 6'h1e;
  assign vd = cnt_reg >= (sync_first ? 6'h05 : 6'h01) && cnt_reg <= (sync_first ? 6'h0f : 6'h0c);
  assign timing_in = {locked, vs, vd, supply_low, xray_over};
endmodule
`default_nettype wire

// file: bench/test_lock_blank_indicator.sv
// Self-checking testbench for the lock and blank indicator
`default_nettype none
module test_lock_blank_indicator;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, go = 1'h0, sync_first = 1'h0, locked = 1'h0;
  logic supply_low = 1'h0, xray_over = 1'h0, vertical_drive_out_en;
  wire lock_blank_pkg::timing_in_s timing_in;
  logic [1:0] lock_blank_composite_out, s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int miscompares = 0, checked = 0;
  lock_blank_indicator lock_blank_indicator_i (.ref_clk, .rst, .timing_in, .lock_blank_composite_out,
    .vertical_drive_out_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  deflection_source deflection_source_i (.ref_clk, .rst, .go, .sync_first, .locked, .supply_low,
    .xray_over, .timing_in);
  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic guard(input int n);
    if (n >= 60) begin
      $display("Error bus wait expected answer seen none");
      miscompares++;
      stop_test();
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Write with address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 60);
    guard(n);
    s_axi_bready <= 1'h0;
    chk("bresp", resp, s_axi_bresp);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 60);
    guard(n);
    s_axi_rready <= 1'h0;
    chk("rresp", resp, s_axi_rresp);
    chk("rdata", d, s_axi_rdata);
  endtask
  // Reset values, then every pairing of hold and lock
  task automatic t_levels();
    step(1);
    chk("drive en", 1'h1, vertical_drive_out_en);
    rd(4'h0, 32'h3, 2'h0);
    for (int h = 0; h < 2; h++) begin
      for (int l = 0; l < 2; l++) begin
        locked <= l[0];
        wr(4'h0, {30'h0, 1'h1, h[0]}, 2'h0);
        step(6);
        chk("composite", {h[0], l[0]}, lock_blank_composite_out);
      end
    end
    $display("test levels done");
  endtask
  // Blank pulse width for both arrival orders, hold off
  task automatic t_frame();
    int n;
    wr(4'h0, 32'h2, 2'h0);
    for (int s = 0; s < 2; s++) begin
      n = 0;
      sync_first <= s[0];
      step(6);
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      repeat (55) begin
        @(posedge ref_clk);
        n += lock_blank_composite_out[1];
      end
      chk("blank width", s ? 15 : 12, n);
    end
    $display("test frame done");
  endtask
  // Forcing conditions and the protection latch
  task automatic t_force();
    supply_low <= 1'h1;
    step(6);
    chk("supply blank", 2'h3, lock_blank_composite_out);
    supply_low <= 1'h0;
    step(6);
    chk("supply over", 2'h1, lock_blank_composite_out);
    xray_over <= 1'h1;
    step(4);
    xray_over <= 1'h0;
    step(8);
    chk("xray held", 2'h3, lock_blank_composite_out);
    rd(4'h4, 32'h35, 2'h0);
    wr(4'h0, 32'h6, 2'h0);
    step(6);
    chk("xray clear", 2'h1, lock_blank_composite_out);
    xray_over <= 1'h1;
    step(4);
    xray_over <= 1'h0;
    supply_low <= 1'h1;
    step(4);
    supply_low <= 1'h0;
    step(8);
    chk("supply clear", 2'h1, lock_blank_composite_out);
    wr(4'h0, 32'h0, 2'h0);
    step(6);
    chk("drive off", 2'h3, lock_blank_composite_out);
    chk("drive en", 1'h0, vertical_drive_out_en);
    $display("test force done");
  endtask
  // Unmapped and read-only places
  task automatic t_bus();
    rd(4'h8, 32'h0, 2'h2);
    wr(4'hc, 32'h1, 2'h2);
    wr(4'h4, 32'hff, 2'h0);
    rd(4'h0, 32'h0, 2'h0);
    // A control write without byte lane 0 leaves the control bits alone
    s_axi_wstrb <= 4'he;
    wr(4'h0, 32'h3, 2'h0);
    rd(4'h0, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hf;
    $display("test bus done");
  endtask
  initial begin
    step(10);
    rst <= 1'h0;
    step(1);
    chk("reset blank", 1'h1, lock_blank_composite_out[1]);
    t_levels();
    t_frame();
    t_force();
    t_bus();
    stop_test();
  end
endmodule
`default_nettype wire
